// *** src/pso_cfg.svh ***
// Purpose: constants for the pipelined sample output port
// Assumes: 40 MHz system clock, 25 ns period
// Notes: times in ns, cycle counts derived from them
`ifndef PSO_CFG_SVH
`define PSO_CFG_SVH
`define PSO_CODE_W 10
`define PSO_CODE_ZERO 10'h000
`define PSO_CODE_TOP 10'h3ff
`define PSO_LATENCY 2
`define PSO_CLK_NS 25
`define PSO_WAKE_NS 700
`define PSO_WAKE_CYC ((`PSO_WAKE_NS + `PSO_CLK_NS - 1) / `PSO_CLK_NS)
`define PSO_FIFO_DEPTH 4
`endif

// *** src/pso_pkg.sv ***
// Purpose: types for the pipelined sample output port
// Assumes: pso_cfg.svh holds the numbers
// Notes: none
`include "pso_cfg.svh"
package pso_pkg;
  typedef logic [`PSO_CODE_W-1:0] pso_code_t;
  typedef struct packed
  {
    logic below;
    logic above;
    pso_code_t code;
  } pso_sample_s;
  typedef enum logic [1:0]
  {
    PSO_SLEEP = 2'b00,
    PSO_WAKE = 2'b01,
    PSO_RUN = 2'b10
  } pso_state_e;
endpackage

// *** src/pso_fifo.sv ***
// Purpose: small valid/ready fifo between sampler and output stage
// Assumes: single clock, synchronous active-low reset
// Notes: full and empty are exact; no write when full
`timescale 1ns/1ps
`default_nettype none
module pso_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // fill side
  input wire logic i_in_valid,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_in_ready,
  // drain side
  output logic o_out_valid,
  output logic [WIDTH-1:0] o_out_data,
  input wire logic i_out_ready
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH)
  begin : g_bad_depth
    $error("pso_fifo: depth must be a power of two >= 2");
  end
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [WIDTH-1:0] mem_d [DEPTH];
  logic [AW:0] wr_q, wr_d, rd_q, rd_d;
  logic push, pop;
  assign o_in_ready = (wr_q - rd_q) != (AW+1)'(DEPTH);
  assign o_out_valid = wr_q != rd_q;
  assign o_out_data = mem_q[rd_q[AW-1:0]];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  always_comb
  begin
    mem_d = mem_q;
    wr_d = wr_q;
    rd_d = rd_q;
    if (push)
    begin
      mem_d[wr_q[AW-1:0]] = i_in_data;
      wr_d = wr_q + 1'b1;
    end
    if (pop)
      rd_d = rd_q + 1'b1;
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      wr_q <= '0;
      rd_q <= '0;
      for (int i = 0; i < DEPTH; i++)
        mem_q[i] <= '0;
    end
    else
    begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      mem_q <= mem_d;
    end
  end
  a_fifo_no_over: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !o_in_ready |-> (wr_q - rd_q) == (AW+1)'(DEPTH))
    else $error("fifo ready low while not full");
endmodule // pso_fifo
`default_nettype wire

// *** src/pso_port.sv ***
// Purpose: digital output side of a 10-bit pipelined sampling converter
// Assumes: samples arrive as codes plus range flags from the quantiser
// Notes: sampling edge is the falling edge of the sample clock pin
//
// Behaviour
// - A sample is taken on each falling sample-clock edge while converting.
// - A sample's code reaches the bus two sample-clock cycles after capture.
// - After the first two cycles of a run, every sample-clock cycle yields a new code in a continuous stream.
// - An input below the lower reference produces the all-zero code.
// - An input above the upper reference produces the all-ones code.
// - Codes are 10-bit unsigned values from zero to the top code.
// - Conversion runs only while the clock toggles and sleep is low.
// - The bus is driven only while the active-low enable is low.
// - While sleep is high the code bus floats; the status outputs stay driven.
// - Each output update happens only after a falling sample-clock edge.
// - The previous word holds for a while after each falling edge.
// - After sleep falls, results during the wake interval are flagged.
`timescale 1ns/1ps
`default_nettype none
`include "pso_cfg.svh"
module pso_port
  import pso_pkg::*;
#(
  parameter int WAKE_CYC = `PSO_WAKE_CYC,
  parameter int LATENCY = `PSO_LATENCY
)(
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // pins from the far side
  input wire logic i_sample_clk,
  input wire logic i_sleep_request,
  input wire logic i_drive_en_n,
  // quantiser result
  input wire logic [`PSO_CODE_W-1:0] i_raw_code,
  input wire logic i_below_ref,
  input wire logic i_above_ref,
  // output bus pins
  output logic [`PSO_CODE_W-1:0] o_code,
  output logic [`PSO_CODE_W-1:0] o_code_oe,
  // status
  output logic o_sample_strobe,
  output logic o_wake_busy,
  output logic o_fifo_stall
);
  // refused at elaboration: the pipe and the wake counter are fixed
  if (LATENCY != 2)
  begin : g_bad_latency
    $error("pso_port: pipeline built for a latency of two");
  end
  if (WAKE_CYC < 1 || WAKE_CYC > 65535)
  begin : g_bad_wake
    $error("pso_port: wake count must fit the 16-bit counter");
  end

  // two-flop synchronisers; first stage read by second only
  logic [2:0] sync1_q, sync2_q, sync1_d, sync2_d;
  logic clk_prev_q, clk_prev_d;
  always_comb
  begin
    sync1_d = {i_sample_clk, i_sleep_request, i_drive_en_n};
    sync2_d = sync1_q;
    clk_prev_d = sync2_q[2];
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= 3'h7;
      sync2_q <= 3'h7;
      clk_prev_q <= 1'b1;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      clk_prev_q <= clk_prev_d;
    end
  end
  logic clk_s, sleep_s, en_n_s, fall;
  assign clk_s = sync2_q[2];
  assign sleep_s = sync2_q[1];
  assign en_n_s = sync2_q[0];
  assign fall = clk_prev_q && !clk_s;

  // sleep / wake state
  pso_state_e st_q, st_d;
  logic [15:0] wake_q, wake_d;
  always_comb
  begin
    st_d = st_q;
    wake_d = wake_q;
    case (st_q)
      PSO_SLEEP:
      begin
        if (!sleep_s)
        begin
          st_d = PSO_WAKE;
          wake_d = 16'(WAKE_CYC);
        end
      end
      PSO_WAKE:
      begin
        if (sleep_s)
          st_d = PSO_SLEEP;
        else if (wake_q <= 16'h0001)
        begin
          st_d = PSO_RUN;
          wake_d = 16'h0000;
        end
        else
          wake_d = wake_q - 16'h0001;
      end
      PSO_RUN:
      begin
        if (sleep_s)
          st_d = PSO_SLEEP;
      end
      default:
        st_d = PSO_SLEEP;
    endcase
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      st_q <= PSO_SLEEP;
      wake_q <= 16'h0000;
    end
    else
    begin
      st_q <= st_d;
      wake_q <= wake_d;
    end
  end
  logic active;
  assign active = (st_q != PSO_SLEEP) && !sleep_s;

  // helper: cycles spent in the wake state, for the bound checks
  logic [15:0] wlen_q, wlen_d;
  always_comb
  begin
    wlen_d = 16'h0000;
    if (st_q == PSO_WAKE)
      wlen_d = wlen_q + 16'h0001;
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
      wlen_q <= 16'h0000;
    else
      wlen_q <= wlen_d;
  end
  a_wake_bound: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    wlen_q <= 16'(WAKE_CYC))
    else $error("wake interval overran its count");
  a_wake_full: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == PSO_WAKE && st_d == PSO_RUN) |-> wlen_q == 16'(WAKE_CYC - 1))
    else $error("wake interval cut short");
  a_wbusy_run: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (st_q == PSO_RUN) |=> !wbusy_q)
    else $error("wake flag high while running");

  // sample capture with clamping
  pso_sample_s smp;
  always_comb
  begin
    smp.below = i_below_ref;
    smp.above = i_above_ref;
    if (i_below_ref)
      smp.code = `PSO_CODE_ZERO;
    else if (i_above_ref)
      smp.code = `PSO_CODE_TOP;
    else
      smp.code = i_raw_code;
  end
  logic take;
  assign take = fall && active;

  // sleep also empties the queue, so a wake never replays stale samples
  logic fifo_rst_n;
  assign fifo_rst_n = i_rst_n && active;
  // stage one: fifo holds captured samples
  logic in_ready, out_valid, pop;
  pso_sample_s fifo_out;
  pso_fifo #(
    .WIDTH($bits(pso_sample_s)),
    .DEPTH(`PSO_FIFO_DEPTH)
  ) u_fifo (
    .i_mclk(i_mclk),
    .i_rst_n(fifo_rst_n),
    .i_in_valid(take),
    .i_in_data(smp),
    .o_in_ready(in_ready),
    .o_out_valid(out_valid),
    .o_out_data(fifo_out),
    .i_out_ready(pop)
  );

  // fill counter: one sample in flight per pending edge
  logic [2:0] depth_q, depth_d;
  logic [`PSO_CODE_W-1:0] out_q, out_d;
  logic wbusy_q, wbusy_d, stall_q, stall_d;
  // second falling edge after capture releases the sample: latency two
  assign pop = fall && active && out_valid && (depth_q >= 3'h2);
  always_comb
  begin
    depth_d = depth_q;
    out_d = out_q;
    wbusy_d = (st_q == PSO_WAKE);
    stall_d = stall_q || (take && !in_ready);
    if (!active)
      depth_d = 3'h0;
    else if (take && in_ready && !pop)
      depth_d = depth_q + 3'h1;
    else if (pop && !(take && in_ready))
      depth_d = depth_q - 3'h1;
    if (pop)
      out_d = fifo_out.code;
    if (!active)
      stall_d = 1'b0;
  end
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_n)
    begin
      depth_q <= 3'h0;
      out_q <= `PSO_CODE_ZERO;
      wbusy_q <= 1'b0;
      stall_q <= 1'b0;
    end
    else
    begin
      depth_q <= depth_d;
      out_q <= out_d;
      wbusy_q <= wbusy_d;
      stall_q <= stall_d;
    end
  end

  // pin drive: float on sleep or enable high
  logic drive;
  assign drive = !sleep_s && !en_n_s;
  assign o_code = out_q;
  assign o_code_oe = {`PSO_CODE_W{drive}};
  assign o_sample_strobe = take;
  assign o_wake_busy = wbusy_q;
  assign o_fifo_stall = stall_q;

  a_float_sleep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sleep_s |-> o_code_oe == '0)
    else $error("bus driven during sleep");
  a_float_en: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    en_n_s |-> o_code_oe == '0)
    else $error("bus driven with enable high");
  a_drive_on: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (!en_n_s && !sleep_s) |-> o_code_oe == '1)
    else $error("bus not driven when enabled");
  a_update_edge: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (out_q != $past(out_q)) |-> $past(fall))
    else $error("output changed without falling edge");
  a_clamp_low: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    i_below_ref |-> smp.code == 10'h000)
    else $error("below-range code not zero");
  a_clamp_high: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    (i_above_ref && !i_below_ref) |-> smp.code == 10'h3ff)
    else $error("above-range code not all ones");
  a_take_sleep: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    sleep_s |-> !take)
    else $error("sample taken while asleep");
  a_wake_flag: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    $rose(st_q == PSO_WAKE) |=> wbusy_q)
    else $error("wake flag not raised");
  a_take_fall: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take |-> $past(clk_s) && !clk_s)
    else $error("sample not on falling edge");
  a_pop_depth: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pop |-> depth_q >= 3'h2)
    else $error("sample released before two cycles");

  // pipeline checks
  a_take_once: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take |=> !take)
    else $error("two samples taken in a row");
  a_take_run: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take |-> st_q != PSO_SLEEP)
    else $error("sample taken in sleep state");
  a_sleep_depth: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !active |=> depth_q == 3'h0)
    else $error("pipe count kept over sleep");
  a_stall_clear: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !active |=> !stall_q)
    else $error("stall flag kept over sleep");
  a_fifo_room: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    take |-> in_ready)
    else $error("sample refused by full queue");
  a_depth_cap: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    depth_q <= 3'h2)
    else $error("more than two samples in flight");
  a_code_follow: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    pop |=> out_q == $past(fifo_out.code))
    else $error("released code not on the bus");
  a_out_hold: assert property (@(posedge i_mclk) disable iff (!i_rst_n)
    !$past(pop) |-> out_q == $past(out_q))
    else $error("output word changed between updates");
endmodule // pso_port
`default_nettype wire

// *** verification/pso_capture.sv ***
// Purpose: far-side capture logic latching words off the sample bus
// Assumes: bus is read on the falling sample-clock edge
// Notes: latching at the fall relies on the old word still holding
`timescale 1ns/1ps
`default_nettype none
module pso_capture
  import pso_pkg::*;
(
  // pins seen
  input wire logic i_sample_clk,
  input wire pso_code_t i_code,
  input wire pso_code_t i_code_oe,
  // captured word
  output pso_code_t o_word,
  output logic o_driven
);
  initial o_word = 10'h000;
  initial o_driven = 1'b0;
  // the fall launches the next word, so the previous one is taken here
  always @(negedge i_sample_clk)
  begin
    // a floated bit reads as the inverse of the code bit the port presents at the fall
    o_word <= ~(i_code ^ i_code_oe);
    o_driven <= &i_code_oe;
  end
endmodule // pso_capture
`default_nettype wire

// *** verification/pso_port_bench.sv ***
// Purpose: self-checking bench for the sample output port
// Assumes: sample clock period of 9 mclk, short wake count
// Notes: first two words after a restart are not judged
`timescale 1ns/1ps
`default_nettype none
module pso_port_bench;
  import pso_pkg::*;
  logic i_mclk, i_rst_n, i_sample_clk, i_sleep_request, i_drive_en_n;
  logic i_below_ref, i_above_ref, o_sample_strobe, o_wake_busy;
  logic o_fifo_stall, cap_driven, seen;
  pso_code_t i_raw_code, o_code, o_code_oe, cap_word;
  pso_code_t exp_q[$];
  int num_errors = 0, checks = 0, strobes = 0, cycles = 0, s0;
  pso_port #(.WAKE_CYC(2)) pso_port_i (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
    .i_sample_clk(i_sample_clk), .i_sleep_request(i_sleep_request),
    .i_drive_en_n(i_drive_en_n), .i_raw_code(i_raw_code),
    .i_below_ref(i_below_ref), .i_above_ref(i_above_ref), .o_code(o_code),
    .o_code_oe(o_code_oe), .o_sample_strobe(o_sample_strobe),
    .o_wake_busy(o_wake_busy), .o_fifo_stall(o_fifo_stall));
  pso_capture pso_capture_i (.i_sample_clk(i_sample_clk), .i_code(o_code),
    .i_code_oe(o_code_oe), .o_word(cap_word), .o_driven(cap_driven));
  initial
  begin
    i_mclk = 1'b0;
    forever #12.5 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk)
  begin
    cycles++;
    if (o_sample_strobe === 1'b1) strobes++;
    if (cycles == 3000)
    begin
      num_errors++;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic check_code(string n, pso_code_t e, pso_code_t g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic check_bit(string n, logic e, logic g);
    checks++;
    if (g !== e)
    begin
      num_errors++;
      $display("[FAIL] %s expected %b seen %b", n, e, g);
    end
  endtask
  task automatic wait_mclk(int n);
    repeat (n) @(posedge i_mclk);
  endtask
  // one sample period; below wins over above
  task automatic step(pso_code_t c, logic lo, logic hi);
    exp_q.push_back(lo ? 10'h000 : (hi ? 10'h3ff : c));
    @(posedge i_mclk);
    i_raw_code <= c;
    i_below_ref <= lo;
    i_above_ref <= hi;
    i_sample_clk <= 1'b0;
    wait_mclk(4);
    i_sample_clk <= 1'b1;
    wait_mclk(4);
    #1;
    if (exp_q.size() >= 3)
      check_code("o_code", exp_q[exp_q.size()-3], o_code);
    if (exp_q.size() >= 4)
      check_code("cap_word", exp_q[exp_q.size()-4], cap_word);
  endtask
  task automatic t_stream();
    exp_q.delete();
    s0 = strobes;
    step(10'h000, 1'b0, 1'b0);
    step(10'h3ff, 1'b0, 1'b0);
    step(10'h001, 1'b0, 1'b0);
    step(10'h3fe, 1'b0, 1'b0);
    step(10'h155, 1'b0, 1'b0);
    step(10'h2aa, 1'b0, 1'b0);
    check_bit("strobes", 1'b1, strobes - s0 == 6);
    check_bit("o_fifo_stall", 1'b0, o_fifo_stall);
    check_bit("cap_driven", 1'b1, cap_driven);
    $display("t_stream done");
  endtask
  task automatic t_range();
    exp_q.delete();
    step(10'h100, 1'b0, 1'b0);
    step(10'h100, 1'b0, 1'b0);
    step(10'h155, 1'b1, 1'b0);
    step(10'h155, 1'b0, 1'b1);
    step(10'h0aa, 1'b1, 1'b1);
    step(10'h3ff, 1'b1, 1'b0);
    step(10'h000, 1'b0, 1'b1);
    step(10'h111, 1'b0, 1'b0);
    step(10'h111, 1'b0, 1'b0);
    $display("t_range done");
  endtask
  task automatic t_enable();
    @(posedge i_mclk);
    i_drive_en_n <= 1'b1;
    wait_mclk(6);
    check_code("o_code_oe", 10'h000, o_code_oe);
    i_drive_en_n <= 1'b0;
    wait_mclk(6);
    check_code("o_code_oe", 10'h3ff, o_code_oe);
    $display("t_enable done");
  endtask
  task automatic t_sleep();
    i_sleep_request <= 1'b1;
    wait_mclk(6);
    check_code("o_code_oe", 10'h000, o_code_oe);
    s0 = strobes;
    repeat (2)
    begin
      i_sample_clk <= 1'b0;
      wait_mclk(4);
      i_sample_clk <= 1'b1;
      wait_mclk(4);
    end
    check_bit("asleep strobes", 1'b1, strobes == s0);
    i_sleep_request <= 1'b0;
    seen = 1'b0;
    repeat (12)
    begin
      @(posedge i_mclk);
      if (o_wake_busy === 1'b1) seen = 1'b1;
    end
    check_bit("wake seen", 1'b1, seen);
    check_bit("o_wake_busy", 1'b0, o_wake_busy);
    $display("t_sleep done");
  endtask
  initial
  begin
    i_rst_n = 1'b0;
    i_sample_clk = 1'b1;
    i_sleep_request = 1'b0;
    i_drive_en_n = 1'b0;
    i_raw_code = 10'h000;
    i_below_ref = 1'b0;
    i_above_ref = 1'b0;
    wait_mclk(10);
    i_rst_n <= 1'b1;
    wait_mclk(12);
    t_stream();
    t_range();
    t_enable();
    t_sleep();
    t_stream();
    wrap_up();
  end
endmodule // pso_port_bench
`default_nettype wire
